// ===== csp_top.sv
// chip-select decode and coprocessor handshake pins with register port
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps

// Contract
// - mid-range selects drive only when enabled by configuration.
// - mid-range selects assert only for memory cycles inside their window.
// - coprocessor mode turns three mid-range pins into the handshake.
// - exception sampled at a numeric operation start raises type 16.
// - in coprocessor mode the select pin is active on coprocessor access.
// - each of five peripheral selects asserts inside its window.
// - two extra peripheral pins may carry latched address bits 2 and 1.
module csp_top
    import csp_pkg::*;
(
    input  wire logic                  clock_i,
    input  wire logic                  rst_i,
    // register port
    input  wire logic [7:0]            reg_addr_i,
    input  wire logic [31:0]           reg_wdata_i,
    input  wire logic                  reg_wr_i,
    input  wire logic                  reg_rd_i,
    output logic      [31:0]           reg_rdata_o,
    // bus cycle from the core
    input  wire logic                  cyc_valid_i,
    input  wire logic                  cyc_is_io_i,
    input  wire logic                  cyc_coproc_i,
    input  wire logic [CSP_ADDR_W-1:0] cyc_addr_i,
    input  wire logic                  numeric_start_i,
    // pins, mid-range group (two-way on 0 and 1)
    input  wire logic                  midrange_sel0_or_coproc_request_i,
    output logic                       midrange_sel0_or_coproc_request_o,
    output logic                       midrange_sel0_or_coproc_request_oe_n_o,
    input  wire logic                  midrange_sel1_or_coproc_exception_i,
    output logic                       midrange_sel1_or_coproc_exception_o,
    output logic                       midrange_sel1_or_coproc_exception_oe_n_o,
    output logic                       midrange_sel2_n_o,
    output logic                       midrange_sel3_or_coproc_select_n_o,
    // pins, peripheral group
    output logic      [CSP_PER_LOW-1:0] peripheral_selects_n_o,
    output logic                       periph_sel5_or_latched_addr1_o,
    output logic                       periph_sel6_or_latched_addr2_o,
    // core side results
    output logic                       coproc_request_o,
    output logic                       exc_trap_o,
    output logic      [7:0]            exc_vector_o,
    output logic                       irq_o
);

    // ****************************************************************
    // registers
    // ****************************************************************
    logic [31:0]             ctrl;
    logic [CSP_ADDR_W-1:0]   mid_lo;
    logic [CSP_ADDR_W-1:0]   mid_hi;
    logic [CSP_ADDR_W-1:0]   per_base;
    logic [CSP_ADDR_W-1:0]   per_size;
    logic [CSP_ST_W-1:0]     status;
    logic [CSP_ST_W-1:0]     int_en;
    logic [CSP_ADDR_W-1:0]   latched_addr;
    logic [CSP_MID_N-1:0]    mid_sel;
    logic [CSP_PER_N-1:0]    per_sel;
    logic                    coproc_sel;
    logic                    req_prev;
    csp_cycle_s              cyc;
    csp_reg_req_s            req;

    // ****************************************************************
    // input gathering and synchronisers
    // ****************************************************************
    assign cyc = '{valid: cyc_valid_i, is_io: cyc_is_io_i,
                   coproc: cyc_coproc_i, addr: cyc_addr_i};
    assign req = '{wr: reg_wr_i, rd: reg_rd_i, addr: reg_addr_i,
                   wdata: reg_wdata_i};

    logic [1:0] pins_sync;
    logic [1:0] mode_age;

    // pins from the coprocessor are asynchronous to our clock
    csp_sync #(.W(2)) u_sync (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .async_i ({midrange_sel1_or_coproc_exception_i,
                   midrange_sel0_or_coproc_request_i}),
        .sync_o  (pins_sync)
    );

    wire mid_en   = ctrl[CSP_CTRL_MID_EN];
    wire coproc_m = ctrl[CSP_CTRL_COPROC];
    wire addr_out = ctrl[CSP_CTRL_ADDR_OUT];

    // the synchroniser still holds our own select drive for two clocks
    // after the pins turn into inputs, so that is waited out first
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            mode_age <= '0;
        end else begin
            mode_age <= {mode_age[0], coproc_m};
        end
    end

    wire pins_live = coproc_m & mode_age[1];
    wire exc_in   = pins_sync[1] & pins_live;
    wire req_in   = pins_sync[0] & pins_live;

    // ****************************************************************
    // decode helpers
    // ****************************************************************
    function automatic logic in_window(input logic [CSP_ADDR_W-1:0] a,
                                       input logic [CSP_ADDR_W-1:0] lo,
                                       input logic [CSP_ADDR_W-1:0] hi);
        in_window = (a >= lo) && (a <= hi);
    endfunction

    // mid-range space is split into four equal slices of the window
    wire [CSP_ADDR_W-1:0] mid_span  = mid_hi - mid_lo;
    wire [CSP_ADDR_W-1:0] mid_off   = cyc.addr - mid_lo;
    wire [CSP_ADDR_W-1:0] mid_slice = mid_span >> 2;
    wire [1:0] mid_idx = (mid_slice == CSP_ADDR_ZERO) ? 2'h0 :
        (mid_off / (mid_slice + 20'h0_0001) > 20'h0_0003) ? 2'h3 :
        2'(mid_off / (mid_slice + 20'h0_0001));
    wire mid_hit = cyc.valid & ~cyc.is_io & ~cyc.coproc
                 & in_window(cyc.addr, mid_lo, mid_hi);

    // peripheral blocks: seven consecutive blocks of per_size bytes
    wire [CSP_ADDR_W-1:0] per_off = cyc.addr - per_base;
    wire [CSP_ADDR_W-1:0] per_top = per_size * 20'h0_0007;
    wire per_hit = cyc.valid & ~cyc.coproc & (per_size != CSP_ADDR_ZERO)
                 & (cyc.addr >= per_base) & (per_off < per_top);
    wire [2:0] per_idx = (per_size == CSP_ADDR_ZERO) ? 3'h0 :
        3'(per_off / per_size);

    // ****************************************************************
    // select registers, active-high inside, inverted at the pins
    // ****************************************************************
    wire [CSP_MID_N-1:0] next_mid_sel =
        (mid_en & mid_hit) ? CSP_MID_N'(1) << mid_idx : '0;
    wire [CSP_PER_N-1:0] next_per_sel =
        per_hit ? CSP_PER_N'(1) << per_idx : '0;
    wire next_coproc_sel = coproc_m & cyc.valid & cyc.coproc;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            mid_sel      <= '0;
            per_sel      <= '0;
            coproc_sel   <= 1'b0;
            latched_addr <= CSP_ADDR_ZERO;
        end else begin
            mid_sel    <= next_mid_sel;
            per_sel    <= next_per_sel;
            coproc_sel <= next_coproc_sel;
            if (cyc.valid) begin
                latched_addr <= cyc.addr;
            end
        end
    end

    // ****************************************************************
    // pin mapping
    // ****************************************************************
    // in coprocessor mode pins 0 and 1 turn into inputs (oe_n high)
    assign midrange_sel0_or_coproc_request_o      = ~mid_sel[0];
    assign midrange_sel0_or_coproc_request_oe_n_o = coproc_m | ~mid_en;
    assign midrange_sel1_or_coproc_exception_o    = ~mid_sel[1];
    assign midrange_sel1_or_coproc_exception_oe_n_o = coproc_m | ~mid_en;
    assign midrange_sel2_n_o = ~mid_sel[2];
    // pin 3 carries the coprocessor select when numerics mode is on
    assign midrange_sel3_or_coproc_select_n_o =
        coproc_m ? ~coproc_sel : ~mid_sel[3];
    assign peripheral_selects_n_o = ~per_sel[CSP_PER_LOW-1:0];
    assign periph_sel5_or_latched_addr1_o =
        addr_out ? latched_addr[1] : ~per_sel[5];
    assign periph_sel6_or_latched_addr2_o =
        addr_out ? latched_addr[2] : ~per_sel[6];

    // ****************************************************************
    // exception trap at numeric operation start
    // ****************************************************************
    wire exc_event = numeric_start_i & exc_in;
    wire req_event = req_in & ~req_prev;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            exc_trap_o   <= 1'b0;
            exc_vector_o <= 8'h00;
            req_prev     <= 1'b0;
        end else begin
            exc_trap_o   <= exc_event;
            exc_vector_o <= exc_event ? CSP_EXC_VECTOR : 8'h00;
            req_prev     <= req_in;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            coproc_request_o <= 1'b0;
        end else begin
            coproc_request_o <= req_in;
        end
    end

    // ****************************************************************
    // register port decode
    // ****************************************************************
    wire wr_ctrl  = req.wr & (req.addr == CSP_REG_CTRL);
    wire wr_mlo   = req.wr & (req.addr == CSP_REG_MID_LO);
    wire wr_mhi   = req.wr & (req.addr == CSP_REG_MID_HI);
    wire wr_pbase = req.wr & (req.addr == CSP_REG_PER_BASE);
    wire wr_psize = req.wr & (req.addr == CSP_REG_PER_SIZE);
    wire wr_inten = req.wr & (req.addr == CSP_REG_INT_EN);
    wire wr_clr   = req.wr & (req.addr == CSP_REG_INT_CLR);

    // an unmapped write is recorded as a status event rather than lost
    wire unmapped_wr = req.wr & ~(wr_ctrl | wr_mlo | wr_mhi | wr_pbase
                     | wr_psize | wr_inten | wr_clr);

    wire [CSP_ST_W-1:0] st_set = {unmapped_wr, req_event, exc_event};
    wire [CSP_ST_W-1:0] st_clr =
        wr_clr ? req.wdata[CSP_ST_W-1:0] : '0;
    // set wins over a clear in the same cycle
    wire [CSP_ST_W-1:0] next_status = (status & ~st_clr) | st_set;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ctrl     <= CSP_CTRL_RESET;
            mid_lo   <= CSP_ADDR_ZERO;
            mid_hi   <= CSP_ADDR_ZERO;
            per_base <= CSP_ADDR_ZERO;
            per_size <= CSP_ADDR_ZERO;
            int_en   <= '0;
            status   <= '0;
        end else begin
            if (wr_ctrl)  ctrl     <= req.wdata;
            if (wr_mlo)   mid_lo   <= req.wdata[CSP_ADDR_W-1:0];
            if (wr_mhi)   mid_hi   <= req.wdata[CSP_ADDR_W-1:0];
            if (wr_pbase) per_base <= req.wdata[CSP_ADDR_W-1:0];
            if (wr_psize) per_size <= req.wdata[CSP_ADDR_W-1:0];
            if (wr_inten) int_en   <= req.wdata[CSP_ST_W-1:0];
            status <= next_status;
        end
    end

    assign irq_o = |(status & int_en);

    // ****************************************************************
    // read mux, data one cycle after the strobe
    // ****************************************************************
    logic [31:0] rd_mux;
    always_comb begin
        unique case (req.addr)
            CSP_REG_CTRL:     rd_mux = {29'h0, ctrl[2:0]};
            CSP_REG_MID_LO:   rd_mux = {12'h000, mid_lo};
            CSP_REG_MID_HI:   rd_mux = {12'h000, mid_hi};
            CSP_REG_PER_BASE: rd_mux = {12'h000, per_base};
            CSP_REG_PER_SIZE: rd_mux = {12'h000, per_size};
            CSP_REG_STATUS:   rd_mux = {29'h0, status};
            CSP_REG_INT_EN:   rd_mux = {29'h0, int_en};
            CSP_REG_PINS:     rd_mux = {18'h0_0000, pins_sync, coproc_sel,
                                        per_sel, mid_sel};
            default:          rd_mux = 32'h0000_0000;  // write-only, unmapped
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else begin
            reg_rdata_o <= req.rd ? rd_mux : 32'h0000_0000;
        end
    end

endmodule

// ===== csp_pkg.sv
// package: register map, fields and types for the chip-select and coprocessor pin block
package csp_pkg;

    // ****************************************************************
    // register offsets (byte addresses, one 32-bit word every 4)
    // ****************************************************************
    localparam logic [7:0] CSP_REG_CTRL     = 8'h00;
    localparam logic [7:0] CSP_REG_MID_LO   = 8'h04;
    localparam logic [7:0] CSP_REG_MID_HI   = 8'h08;
    localparam logic [7:0] CSP_REG_PER_BASE = 8'h0C;
    localparam logic [7:0] CSP_REG_PER_SIZE = 8'h10;
    localparam logic [7:0] CSP_REG_STATUS   = 8'h14;
    localparam logic [7:0] CSP_REG_INT_EN   = 8'h18;
    localparam logic [7:0] CSP_REG_INT_CLR  = 8'h1C;
    localparam logic [7:0] CSP_REG_PINS     = 8'h20;

    // ****************************************************************
    // control register fields
    // ****************************************************************
    localparam int CSP_CTRL_MID_EN   = 0;
    localparam int CSP_CTRL_COPROC   = 1;
    localparam int CSP_CTRL_ADDR_OUT = 2;
    localparam logic [31:0] CSP_CTRL_RESET = 32'h0000_0000;

    // ****************************************************************
    // window layout and status bits
    // ****************************************************************
    localparam int CSP_ADDR_W   = 20;
    localparam int CSP_MID_N    = 4;
    localparam int CSP_PER_N    = 7;
    localparam int CSP_PER_LOW  = 5;
    localparam int CSP_ST_W     = 3;
    localparam int CSP_ST_EXC   = 0;
    localparam int CSP_ST_REQ   = 1;
    localparam int CSP_ST_UNMAP = 2;
    localparam logic [7:0] CSP_EXC_VECTOR = 8'h10;   // interrupt type 16
    localparam logic [CSP_ADDR_W-1:0] CSP_ADDR_ZERO = 20'h0_0000;

    // bus cycle as seen from the core
    typedef struct packed {
        logic                  valid;
        logic                  is_io;
        logic                  coproc;
        logic [CSP_ADDR_W-1:0] addr;
    } csp_cycle_s;

    // register port request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } csp_reg_req_s;

endpackage

// ===== csp_sync.sv
// two-flop synchroniser for the coprocessor handshake inputs
`timescale 1ns/1ps
module csp_sync
    import csp_pkg::*;
#(
    parameter int W = 2
) (
    input  wire logic         clock_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta;

    // ****************************************************************
    // first stage feeds only the second
    // ****************************************************************
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            meta   <= '0;
            sync_o <= '0;
        end else begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end
endmodule

// ===== csp_sva.sv
// checker: timing relations on the chip-select and coprocessor pins
`timescale 1ns/1ps
module csp_sva
    import csp_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    input  wire logic       cyc_valid_i,
    input  wire logic       cyc_is_io_i,
    input  wire logic       cyc_coproc_i,
    input  wire logic       numeric_start_i,
    input  wire logic       midrange_sel0_or_coproc_request_i,
    input  wire logic       midrange_sel0_or_coproc_request_oe_n_o,
    input  wire logic       midrange_sel1_or_coproc_exception_oe_n_o,
    input  wire logic       midrange_sel2_n_o,
    input  wire logic       midrange_sel3_or_coproc_select_n_o,
    input  wire logic [4:0] peripheral_selects_n_o,
    input  wire logic       coproc_request_o,
    input  wire logic       exc_trap_o,
    input  wire logic [7:0] exc_vector_o
);
    // ****************************************************************
    // select and handshake relations, one clock domain
    // ****************************************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    a_reset_idle_high: assert property ($fell(rst_i) |->
        midrange_sel2_n_o && midrange_sel3_or_coproc_select_n_o
        && &peripheral_selects_n_o && midrange_sel0_or_coproc_request_oe_n_o)
        else $error("select not idle after reset");
    a_io_no_mid: assert property (cyc_valid_i && cyc_is_io_i |=>
        midrange_sel2_n_o) else $error("mid select on io cycle");
    a_mid_has_cause: assert property (!midrange_sel2_n_o |->
        $past(cyc_valid_i && !cyc_is_io_i && !cyc_coproc_i))
        else $error("mid select without memory cycle");
    a_per_has_cause: assert property (!(&peripheral_selects_n_o) |->
        $past(cyc_valid_i && !cyc_coproc_i))
        else $error("peripheral select without cycle");
    a_per_one_hot: assert property (
        $countones(~peripheral_selects_n_o) <= 1)
        else $error("two peripheral selects at once");
    a_trap_vector: assert property (exc_trap_o |->
        $past(numeric_start_i) && exc_vector_o == CSP_EXC_VECTOR)
        else $error("trap without start or wrong vector");
    a_vector_idle: assert property (!exc_trap_o |->
        exc_vector_o == 8'h00) else $error("vector without trap");
    a_csel_cause: assert property (!midrange_sel3_or_coproc_select_n_o
        && midrange_sel0_or_coproc_request_oe_n_o |->
        $past(cyc_valid_i && cyc_coproc_i))
        else $error("coprocessor select without access");
    a_req_delay: assert property ($rose(coproc_request_o) |->
        $past(midrange_sel0_or_coproc_request_i, 2)
        || $past(midrange_sel0_or_coproc_request_i, 3)
        || $past(midrange_sel0_or_coproc_request_i, 4))
        else $error("request rose without pin");
    a_oe_pair: assert property (midrange_sel0_or_coproc_request_oe_n_o
        == midrange_sel1_or_coproc_exception_oe_n_o)
        else $error("handshake pins split");
    // main scenarios reached
    c_trap: cover property (exc_trap_o);
    c_csel: cover property (!midrange_sel3_or_coproc_select_n_o);
    c_req: cover property ($rose(coproc_request_o));
endmodule

bind csp_top csp_sva u_sva (.clock_i, .rst_i, .cyc_valid_i, .cyc_is_io_i,
    .cyc_coproc_i, .numeric_start_i, .midrange_sel0_or_coproc_request_i,
    .midrange_sel0_or_coproc_request_oe_n_o,
    .midrange_sel1_or_coproc_exception_oe_n_o, .midrange_sel2_n_o,
    .midrange_sel3_or_coproc_select_n_o, .peripheral_selects_n_o,
    .coproc_request_o, .exc_trap_o, .exc_vector_o);

// ===== csp_coproc_model.sv
// far side model: numeric coprocessor handshake outputs
`timescale 1ns/1ps
module csp_coproc_model (
    input  wire logic clock_i,
    input  wire logic rst_i,
    input  wire logic pend_i,
    input  wire logic fail_i,
    output logic      request_o,
    output logic      exception_o
);
    // pins move just after an edge; quiet low while reset holds
    always_ff @(posedge clock_i) begin
        request_o   <= !rst_i && pend_i;
        exception_o <= !rst_i && fail_i;
    end
endmodule

// ===== csp_top_bench.sv
// bench: self-checking run of the chip-select and coprocessor pin block
`timescale 1ns/1ps
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin \
    bad_count++; $display("CHECK FAILED %s exp %h got %h", nm, e, s); end end
module csp_top_bench
    import csp_pkg::*;
;
    typedef struct packed {logic [1:0] k; logic [31:0] e; logic [31:0] m;} csp_note_s;
    logic clock_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, probe = 0;
    logic cyc_valid_i = 0, cyc_is_io_i = 0, cyc_coproc_i = 0;
    logic numeric_start_i = 0, pend = 0, fail = 0, m_req, m_exc;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0000_0000, reg_rdata_o, obs, r;
    logic [CSP_ADDR_W-1:0] cyc_addr_i = CSP_ADDR_ZERO;
    logic s0_o, s0_oe_n, s1_o, s1_oe_n, s2_n, s3_n, p5, p6, creq, trap, irq;
    logic [4:0] pcs_n;
    logic [7:0] vec;
    logic [3:0] due;
    logic mid_en = 0, cop = 0, aout = 0;
    int seed = 32'hc6011359, bad_count = 0, comparisons = 0, cycles = 0;
    csp_note_s q[$], n;
    logic [19:0] fixed [6] = '{20'h0_0000, 20'h3_FFFF, 20'h4_0000,
                               20'h8_0600, 20'h8_06FF, 20'h8_0700};
    // the bench resolves the two-way pins from the DUT's output enables alone
    wire pin0 = s0_oe_n ? m_req : s0_o;
    wire pin1 = s1_oe_n ? m_exc : s1_o;
    always #50 clock_i = ~clock_i;
    csp_coproc_model u_cop (.clock_i(clock_i), .rst_i(rst_i), .pend_i(pend),
        .fail_i(fail), .request_o(m_req), .exception_o(m_exc));
    csp_top DUT (.clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .cyc_valid_i(cyc_valid_i),
        .cyc_is_io_i(cyc_is_io_i), .cyc_coproc_i(cyc_coproc_i),
        .cyc_addr_i(cyc_addr_i), .numeric_start_i(numeric_start_i),
        .midrange_sel0_or_coproc_request_i(pin0),
        .midrange_sel0_or_coproc_request_o(s0_o),
        .midrange_sel0_or_coproc_request_oe_n_o(s0_oe_n),
        .midrange_sel1_or_coproc_exception_i(pin1),
        .midrange_sel1_or_coproc_exception_o(s1_o),
        .midrange_sel1_or_coproc_exception_oe_n_o(s1_oe_n),
        .midrange_sel2_n_o(s2_n), .midrange_sel3_or_coproc_select_n_o(s3_n),
        .peripheral_selects_n_o(pcs_n), .periph_sel5_or_latched_addr1_o(p5),
        .periph_sel6_or_latched_addr2_o(p6), .coproc_request_o(creq),
        .exc_trap_o(trap), .exc_vector_o(vec), .irq_o(irq));
    // ****************************************************************
    // expected pin word: {oe1, oe0, per6..per0, mid3..mid0}, low active
    // ****************************************************************
    function automatic logic [31:0] pins_exp(logic [19:0] a, logic io, logic cp);
        logic [31:0] x;
        x = {19'h0, {2{~(mid_en & ~cop)}}, 11'h7FF};
        if (mid_en && !io && !cp && a[19:18] == 2'h0 && !(cop && a[17:16] == 2'h3))
            x[a[17:16]] = 1'b0;
        if (cop && cp) x[3] = 1'b0;
        if (!cp && a[19:12] == 8'h80 && a[11:8] < 4'h7) x[4 + a[10:8]] = 1'b0;
        if (aout) x[10:9] = a[2:1];
        return x;
    endfunction
    // every task but idle and test_done spends one edge and sets each strobe once
    task automatic drive(logic wr, logic rd, logic [7:0] a, logic [31:0] d,
                         logic v, logic st, logic pb);
        @(posedge clock_i);
        reg_wr_i <= wr;
        reg_rd_i <= rd;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        cyc_valid_i <= v;
        numeric_start_i <= st;
        probe <= pb;
    endtask
    task automatic idle(int c);
        repeat (c) drive(0, 0, 8'h00, 32'h0000_0000, 0, 0, 0);
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        drive(1, 0, a, d, 0, 0, 0);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m);
        q.push_back('{2'd0, e & m, m});
        drive(0, 1, a, 32'h0000_0000, 0, 0, 0);
    endtask
    task automatic cyc(logic [19:0] a, logic io, logic cp);
        logic [31:0] m;
        m = (mid_en & ~cop) ? 32'h0000_1FFF : 32'h0000_1FFC;
        q.push_back('{2'd1, pins_exp(a, io, cp) & m, m});
        drive(0, 0, 8'h00, 32'h0000_0000, 1, 0, 0);
        cyc_addr_i <= a;
        cyc_is_io_i <= io;
        cyc_coproc_i <= cp;
    endtask
    task automatic start(logic e);
        q.push_back('{2'd2, e ? {23'h0, CSP_EXC_VECTOR, 1'b1} : 32'h0, '1});
        drive(0, 0, 8'h00, 32'h0000_0000, 0, 1, 0);
    endtask
    task automatic peek(logic [31:0] e, logic [31:0] m);
        q.push_back('{2'd3, e & m, m});
        drive(0, 0, 8'h00, 32'h0000_0000, 0, 0, 1);
    endtask
    task automatic test_done();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // monitor: sees what was sampled at the edge, judges settled outputs
    always @(posedge clock_i) begin
        due = {probe, numeric_start_i, cyc_valid_i, reg_rd_i};
        #1;
        if (due != 4'h0) begin
            n = q.pop_front();
            case (n.k)
                2'd0: `CHK("rdata", n.e, reg_rdata_o & n.m)
                2'd1: begin
                    obs = {19'h0, s1_oe_n, s0_oe_n, p6, p5, pcs_n, s3_n, s2_n, s1_o, s0_o};
                    `CHK("pins", n.e, obs & n.m)
                end
                2'd2: `CHK("trap", n.e, {23'h0, vec, trap})
                default: `CHK("irq_req", n.e, {30'h0, irq, creq} & n.m)
            endcase
        end
    end
    // hang guard: a run of this length ends long before the ceiling
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            test_done();
        end
    end
    initial begin
        repeat (3) @(posedge clock_i);
        rst_i <= 0;
        rd(CSP_REG_CTRL, 32'h0000_0000, '1);
        rd(CSP_REG_STATUS, 32'h0000_0000, '1);
        cyc(20'h2_0000, 0, 0);
        rd(8'h44, 32'h0000_0000, '1);
        wr(8'h40, 32'h0000_0001);
        rd(CSP_REG_STATUS, 32'h0000_0004, '1);
        wr(CSP_REG_INT_CLR, 32'h0000_0007);
        rd(CSP_REG_STATUS, 32'h0000_0000, '1);
        wr(CSP_REG_MID_LO, 32'h0000_0000);
        wr(CSP_REG_MID_HI, 32'h0003_FFFF);
        wr(CSP_REG_PER_BASE, 32'h0008_0000);
        wr(CSP_REG_PER_SIZE, 32'h0000_0100);
        // four modes: {addr-out, coprocessor, mid enable} = 001, 011, 101, 000
        for (int c = 0; c < 4; c++) begin
            {aout, cop, mid_en} = (c == 0) ? 3'h1 : (c == 1) ? 3'h3 : (c == 2) ? 3'h5 : 3'h0;
            wr(CSP_REG_CTRL, {29'h0, aout, cop, mid_en});
            foreach (fixed[i]) cyc(fixed[i], 0, 0);
            for (int i = 0; i < 24; i++) begin
                r = $random(seed);
                cyc(r[19] ? {8'h80, r[11:0]} : {2'h0, r[17:0]}, r[18] & r[13], r[12] & r[14]);
            end
        end
        // exception trap raises the interrupt, masked, then cleared
        wr(CSP_REG_CTRL, 32'h0000_0003);
        fail <= 1;
        wr(CSP_REG_INT_EN, 32'h0000_0001);
        idle(4);
        start(1);
        peek(32'h0000_0002, 32'h0000_0002);
        rd(CSP_REG_STATUS, 32'h0000_0001, 32'h0000_0001);
        wr(CSP_REG_INT_EN, 32'h0000_0000);
        peek(32'h0000_0000, 32'h0000_0002);
        wr(CSP_REG_INT_CLR, 32'h0000_0001);
        fail <= 0;
        idle(4);
        start(0);
        wr(CSP_REG_CTRL, 32'h0000_0001);
        fail <= 1;
        idle(4);
        start(0);
        rd(CSP_REG_STATUS, 32'h0000_0000, 32'h0000_0001);
        // transfer request reaches the core and the sticky status bit
        wr(CSP_REG_CTRL, 32'h0000_0003);
        fail <= 0;
        wr(CSP_REG_INT_EN, 32'h0000_0002);
        idle(2);
        rd(CSP_REG_STATUS, 32'h0000_0000, 32'h0000_0002);
        pend <= 1;
        idle(6);
        peek(32'h0000_0003, 32'h0000_0003);
        rd(CSP_REG_PINS, 32'h0000_1000, '1);
        rd(CSP_REG_STATUS, 32'h0000_0002, 32'h0000_0002);
        pend <= 0;
        idle(6);
        peek(32'h0000_0002, 32'h0000_0003);
        wr(CSP_REG_INT_CLR, 32'h0000_0002);
        peek(32'h0000_0000, 32'h0000_0003);
        // second reset in mid-run brings the control word back
        idle(1);
        rst_i <= 1;
        idle(2);
        rst_i <= 0;
        rd(CSP_REG_CTRL, 32'h0000_0000, '1);
        idle(3);
        test_done();
    end
endmodule
